// ### hdl/tssp_test_select.sv
//
// Contract
// - Write-only reserved byte at 39h, resets 00h.
// - Write-only analog probe select at 3Ah, resets 00h.
// - Low nibble picks analog node; D-F reserved.
// - Write-only preset byte 3Bh, 00h, unchanged.
// - Write-only preset byte 3Ch, 00h, unchanged.
// - Write-only digital probe select at 3Dh, 00h.
// - Override bit set drives digital probe signal.
// - Override clear: pin follows normal three-bit choice.
// - Seven-bit code selects one of seven signals.
`timescale 1ns/1ps
module tssp_test_select (
  // Clock and reset
  input  wire logic                                  clk_i,
  input  wire logic                                  rstn_i,
  // Avalon-MM slave
  input  wire logic [tssp_pkg::ADDR_W-1:0]           avs_address_i,
  input  wire logic                                  avs_read_i,
  input  wire logic                                  avs_write_i,
  input  wire logic [tssp_pkg::DATA_W-1:0]           avs_writedata_i,
  input  wire logic [3:0]                            avs_byteenable_i,
  output logic      [tssp_pkg::DATA_W-1:0]           avs_readdata_o,
  output logic                                       avs_waitrequest_o,
  // Normal signal output selection
  input  wire logic [tssp_pkg::NORMAL_CHOICE_W-1:0]  normal_output_choice_i,
  input  wire logic [tssp_pkg::NORMAL_SRC_W-1:0]     normal_src_i,
  // Internal digital probe sources
  input  wire logic [tssp_pkg::DIG_SRC_W-1:0]        dig_probe_src_i,
  // Probe outputs
  output logic                                       signal_output_pin_o,
  output logic      [tssp_pkg::ANA_CODE_W-1:0]       analog_probe_code_o,
  output logic                                       analog_probe_valid_o
);

  logic [tssp_pkg::NUM_WO_REGS-1:0][7:0] reg_q;
  logic [tssp_pkg::NUM_WO_REGS-1:0][7:0] reg_d;
  logic [tssp_pkg::NUM_WO_REGS-1:0][7:0] reg_idx;
  logic                                  wait_q;
  logic                                  wait_d;
  logic [tssp_pkg::DATA_W-1:0]           rdata_q;
  logic [tssp_pkg::DATA_W-1:0]           rdata_d;
  logic                                  pin_q;
  logic                                  pin_d;
  logic [tssp_pkg::ANA_CODE_W-1:0]       ana_q;
  logic [tssp_pkg::ANA_CODE_W-1:0]       ana_d;
  logic                                  ana_valid_q;
  logic                                  ana_valid_d;
  logic                                  req;
  logic                                  wr_take;
  logic                                  lane0;
  logic [7:0]                            word_idx;
  logic                                  override;
  logic [tssp_pkg::DIG_CODE_W-1:0]       dig_code;
  logic                                  dig_valid;
  logic                                  dig_bit;
  logic [tssp_pkg::ANA_CODE_W-1:0]       ana_code;
  logic                                  status_hit;

  assign reg_idx[0] = tssp_pkg::REG_RESERVED_IDX;
  assign reg_idx[1] = tssp_pkg::REG_ANALOG_IDX;
  assign reg_idx[2] = tssp_pkg::REG_PRESET_A_IDX;
  assign reg_idx[3] = tssp_pkg::REG_PRESET_B_IDX;
  assign reg_idx[4] = tssp_pkg::REG_DIGITAL_IDX;

  assign req      = avs_read_i | avs_write_i;
  assign word_idx = avs_address_i[9:2];
  assign lane0    = avs_byteenable_i[0];
  // A write takes effect only on the edge where waitrequest is seen low.
  assign wr_take  = avs_write_i & ~wait_q & lane0;

  assign override = reg_q[4][tssp_pkg::DIG_OVERRIDE_BIT];
  assign dig_code = reg_q[4][tssp_pkg::DIG_CODE_W-1:0];
  assign ana_code = reg_q[1][tssp_pkg::ANA_CODE_LSB +: tssp_pkg::ANA_CODE_W];

  // Bus handshake: one wait cycle, then a single-cycle answer.
  always_comb begin
    wait_d  = ~(req & wait_q);
    rdata_d = rdata_q;
    status_hit = (word_idx == tssp_pkg::REG_STATUS_IDX);
    if (avs_read_i && wait_q) begin
      // Test bytes are write-only and read as zero, as do unmapped words.
      rdata_d = '0;
      if (status_hit) begin
        rdata_d[tssp_pkg::ST_ANA_CODE_LSB +: tssp_pkg::ANA_CODE_W] = ana_q;
        rdata_d[tssp_pkg::ST_ANA_VALID_BIT] = ana_valid_q;
        rdata_d[tssp_pkg::ST_OVERRIDE_BIT]  = override;
        rdata_d[tssp_pkg::ST_DIG_VALID_BIT] = dig_valid;
        rdata_d[tssp_pkg::ST_PIN_BIT]       = pin_q;
        rdata_d[tssp_pkg::ST_DIG_CODE_LSB +: tssp_pkg::DIG_CODE_W] = dig_code;
      end
    end
  end

  // Write-only byte bank; reserved and preset bytes are stored but steer nothing.
  for (genvar g = 0; g < tssp_pkg::NUM_WO_REGS; g++) begin : g_bank
    always_comb begin
      reg_d[g] = reg_q[g];
      if (wr_take && (word_idx == reg_idx[g])) begin
        reg_d[g] = avs_writedata_i[7:0];
      end
    end
  end

  // Digital probe decode; codes outside the defined set give a low pin while the override bit is set.
  always_comb begin
    dig_valid = 1'b1;
    case (dig_code)
      tssp_pkg::DIG_S_DATA:    dig_bit = dig_probe_src_i[tssp_pkg::SRC_S_DATA];
      tssp_pkg::DIG_S_VALID:   dig_bit = dig_probe_src_i[tssp_pkg::SRC_S_VALID];
      tssp_pkg::DIG_S_COLL:    dig_bit = dig_probe_src_i[tssp_pkg::SRC_S_COLL];
      tssp_pkg::DIG_S_CLOCK:   dig_bit = dig_probe_src_i[tssp_pkg::SRC_S_CLOCK];
      tssp_pkg::DIG_RD_SYNC:   dig_bit = dig_probe_src_i[tssp_pkg::SRC_RD_SYNC];
      tssp_pkg::DIG_WR_SYNC:   dig_bit = dig_probe_src_i[tssp_pkg::SRC_WR_SYNC];
      tssp_pkg::DIG_INT_CLOCK: dig_bit = dig_probe_src_i[tssp_pkg::SRC_INT_CLOCK];
      default: begin
        dig_bit   = 1'b0;
        dig_valid = 1'b0;
      end
    endcase
  end

  // Output pin and analog probe; both add one cycle of latency from the sources.
  always_comb begin
    if (override) begin
      pin_d = dig_bit;
    end else begin
      pin_d = normal_src_i[normal_output_choice_i];
    end
    // The upper nibble is ignored so a stray write there cannot move the probe.
    ana_d       = ana_code;
    ana_valid_d = (ana_code <= tssp_pkg::ANA_CODE_MAX);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < tssp_pkg::NUM_WO_REGS; i++) begin
        reg_q[i] <= tssp_pkg::REG_RESET;
      end
      wait_q      <= 1'b1;
      rdata_q     <= '0;
      pin_q       <= 1'b0;
      ana_q       <= '0;
      ana_valid_q <= 1'b1;
    end else begin
      reg_q       <= reg_d;
      wait_q      <= wait_d;
      rdata_q     <= rdata_d;
      pin_q       <= pin_d;
      ana_q       <= ana_d;
      ana_valid_q <= ana_valid_d;
    end
  end

  assign avs_waitrequest_o    = wait_q;
  assign avs_readdata_o       = rdata_q;
  assign signal_output_pin_o  = pin_q;
  assign analog_probe_code_o  = ana_q;
  assign analog_probe_valid_o = ana_valid_q;

  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_rsv_write;
    wr_take && word_idx == tssp_pkg::REG_RESERVED_IDX
      |=> reg_q[0] == $past(avs_writedata_i[7:0]);
  endproperty
  a_rsv_write: assert property (p_rsv_write) else $error("reserved byte not stored");

  property p_ana_write;
    wr_take && word_idx == tssp_pkg::REG_ANALOG_IDX
      |=> ##1 analog_probe_code_o == $past(avs_writedata_i[3:0], 2);
  endproperty
  a_ana_write: assert property (p_ana_write) else $error("analog code not routed");

  property p_ana_valid;
    analog_probe_valid_o == ($past(ana_code) <= tssp_pkg::ANA_CODE_MAX);
  endproperty
  a_ana_valid: assert property (p_ana_valid) else $error("analog valid wrong");

  property p_preset_a;
    !(wr_take && word_idx == tssp_pkg::REG_PRESET_A_IDX) |=> $stable(reg_q[2]);
  endproperty
  a_preset_a: assert property (p_preset_a) else $error("preset a changed");

  property p_preset_b;
    !(wr_take && word_idx == tssp_pkg::REG_PRESET_B_IDX) |=> $stable(reg_q[3]);
  endproperty
  a_preset_b: assert property (p_preset_b) else $error("preset b changed");

  property p_dig_write;
    wr_take && word_idx == tssp_pkg::REG_DIGITAL_IDX
      |=> override == $past(avs_writedata_i[7]);
  endproperty
  a_dig_write: assert property (p_dig_write) else $error("digital select not stored");

  property p_override_data;
    override && dig_code == tssp_pkg::DIG_S_DATA
      |=> signal_output_pin_o == $past(dig_probe_src_i[tssp_pkg::SRC_S_DATA]);
  endproperty
  a_override_data: assert property (p_override_data) else $error("probe not on pin");

  property p_normal;
    !override |=> signal_output_pin_o == $past(normal_src_i[normal_output_choice_i]);
  endproperty
  a_normal: assert property (p_normal) else $error("normal choice not on pin");

  property p_int_clock;
    override && dig_code == tssp_pkg::DIG_INT_CLOCK
      |=> signal_output_pin_o == $past(dig_probe_src_i[tssp_pkg::SRC_INT_CLOCK]);
  endproperty
  a_int_clock: assert property (p_int_clock) else $error("int clock not on pin");

  property p_undef_low;
    override && !dig_valid |=> !signal_output_pin_o;
  endproperty
  a_undef_low: assert property (p_undef_low) else $error("undefined code not low");

  property p_answer;
    req && wait_q |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer timing wrong");

  property p_wait_idle;
    !req |=> avs_waitrequest_o;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low without request");

  // Read data must not move between answers, or a slow master would see it change.
  property p_rdata_hold;
    !(avs_read_i && wait_q) |=> $stable(avs_readdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved between reads");

  property p_rd_zero;
    avs_read_i && wait_q && !status_hit |=> avs_readdata_o == '0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("write-only read not zero");

  property p_status_rd;
    avs_read_i && wait_q && status_hit
      |=> avs_readdata_o[tssp_pkg::ST_OVERRIDE_BIT] == $past(override)
          && avs_readdata_o[tssp_pkg::ST_PIN_BIT] == $past(pin_q);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");

  property p_lane_off;
    avs_write_i && !wait_q && !lane0 |=> $stable(reg_q);
  endproperty
  a_lane_off: assert property (p_lane_off) else $error("masked write landed");

  property p_dig_code;
    wr_take && word_idx == tssp_pkg::REG_DIGITAL_IDX
      |=> dig_code == $past(avs_writedata_i[6:0]);
  endproperty
  a_dig_code: assert property (p_dig_code) else $error("digital code not stored");

  // The upper nibble never reaches the probe, whatever software left there.
  property p_ana_path;
    analog_probe_code_o == $past(ana_code);
  endproperty
  a_ana_path: assert property (p_ana_path) else $error("analog code path wrong");

  property p_ana_rsvd;
    ana_code > tssp_pkg::ANA_CODE_MAX |=> !analog_probe_valid_o;
  endproperty
  a_ana_rsvd: assert property (p_ana_rsvd) else $error("reserved analog code valid");

  // Every defined code must reach the pin, not only the first and the last.
  property p_ovr_valid;
    override && dig_code == tssp_pkg::DIG_S_VALID
      |=> signal_output_pin_o == $past(dig_probe_src_i[tssp_pkg::SRC_S_VALID]);
  endproperty
  a_ovr_valid: assert property (p_ovr_valid) else $error("valid probe not on pin");

  property p_ovr_coll;
    override && dig_code == tssp_pkg::DIG_S_COLL
      |=> signal_output_pin_o == $past(dig_probe_src_i[tssp_pkg::SRC_S_COLL]);
  endproperty
  a_ovr_coll: assert property (p_ovr_coll) else $error("collision probe not on pin");

  property p_ovr_sclock;
    override && dig_code == tssp_pkg::DIG_S_CLOCK
      |=> signal_output_pin_o == $past(dig_probe_src_i[tssp_pkg::SRC_S_CLOCK]);
  endproperty
  a_ovr_sclock: assert property (p_ovr_sclock) else $error("serial clock not on pin");

  property p_ovr_rdsync;
    override && dig_code == tssp_pkg::DIG_RD_SYNC
      |=> signal_output_pin_o == $past(dig_probe_src_i[tssp_pkg::SRC_RD_SYNC]);
  endproperty
  a_ovr_rdsync: assert property (p_ovr_rdsync) else $error("read sync not on pin");

  property p_ovr_wrsync;
    override && dig_code == tssp_pkg::DIG_WR_SYNC
      |=> signal_output_pin_o == $past(dig_probe_src_i[tssp_pkg::SRC_WR_SYNC]);
  endproperty
  a_ovr_wrsync: assert property (p_ovr_wrsync) else $error("write sync not on pin");

  c_override: cover property (wr_take && word_idx == tssp_pkg::REG_DIGITAL_IDX
                              && avs_writedata_i[7]);
  c_ana_rsvd: cover property (ana_code > tssp_pkg::ANA_CODE_MAX);
  c_status:   cover property (avs_read_i && !wait_q && status_hit);
  c_undef:    cover property (override && !dig_valid);
  c_normal:   cover property (!override && normal_output_choice_i == 3'h7);

endmodule : tssp_test_select

// ### inc/tssp_pkg.sv
package tssp_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] REG_RESERVED_IDX  = 8'h39;
  localparam logic [7:0] REG_ANALOG_IDX    = 8'h3A;
  localparam logic [7:0] REG_PRESET_A_IDX  = 8'h3B;
  localparam logic [7:0] REG_PRESET_B_IDX  = 8'h3C;
  localparam logic [7:0] REG_DIGITAL_IDX   = 8'h3D;
  localparam logic [7:0] REG_STATUS_IDX    = 8'h41;

  localparam int         ADDR_W            = 10;
  localparam int         DATA_W            = 32;
  localparam int         NUM_WO_REGS       = 5;
  localparam logic [7:0] REG_RESET         = 8'h00;

  // Field layout.
  localparam int         ANA_CODE_LSB      = 0;
  localparam int         ANA_CODE_W        = 4;
  localparam logic [3:0] ANA_CODE_MAX      = 4'hC;
  localparam int         DIG_OVERRIDE_BIT  = 7;
  localparam int         DIG_CODE_W        = 7;
  localparam int         NORMAL_CHOICE_W   = 3;
  localparam int         NORMAL_SRC_W      = 8;

  // Digital probe codes.
  localparam logic [6:0] DIG_S_DATA        = 7'h74;
  localparam logic [6:0] DIG_S_VALID       = 7'h64;
  localparam logic [6:0] DIG_S_COLL        = 7'h54;
  localparam logic [6:0] DIG_S_CLOCK       = 7'h44;
  localparam logic [6:0] DIG_RD_SYNC       = 7'h35;
  localparam logic [6:0] DIG_WR_SYNC       = 7'h25;
  localparam logic [6:0] DIG_INT_CLOCK     = 7'h16;
  localparam int         DIG_SRC_W         = 7;

  // Bit positions within the digital probe source bus.
  localparam int         SRC_S_DATA        = 0;
  localparam int         SRC_S_VALID       = 1;
  localparam int         SRC_S_COLL        = 2;
  localparam int         SRC_S_CLOCK       = 3;
  localparam int         SRC_RD_SYNC       = 4;
  localparam int         SRC_WR_SYNC       = 5;
  localparam int         SRC_INT_CLOCK     = 6;

  // Status register layout.
  localparam int         ST_ANA_CODE_LSB   = 0;
  localparam int         ST_ANA_VALID_BIT  = 4;
  localparam int         ST_OVERRIDE_BIT   = 5;
  localparam int         ST_DIG_VALID_BIT  = 6;
  localparam int         ST_PIN_BIT        = 7;
  localparam int         ST_DIG_CODE_LSB   = 8;

endpackage : tssp_pkg

// ### testbench/tssp_test_select_tb.sv
`timescale 1ns/1ps
module tssp_test_select_tb;
  logic                                 clk_i            = 1'b0;
  logic                                 rstn_i           = 1'b0;
  logic [tssp_pkg::ADDR_W-1:0]          avs_address_i    = '0;
  logic                                 avs_read_i       = 1'b0;
  logic                                 avs_write_i      = 1'b0;
  logic [tssp_pkg::DATA_W-1:0]          avs_writedata_i  = '0;
  logic [3:0]                           avs_byteenable_i = 4'hF;
  logic [tssp_pkg::DATA_W-1:0]          avs_readdata_o;
  logic                                 avs_waitrequest_o;
  logic [tssp_pkg::NORMAL_CHOICE_W-1:0] normal_output_choice_i = 3'h1;
  logic [tssp_pkg::NORMAL_SRC_W-1:0]    normal_src_i     = 8'h02;
  logic [tssp_pkg::DIG_SRC_W-1:0]       dig_probe_src_i  = '0;
  logic                                 signal_output_pin_o;
  logic [tssp_pkg::ANA_CODE_W-1:0]      analog_probe_code_o;
  logic                                 analog_probe_valid_o;
  logic [31:0]                          rd;
  logic [6:0]                           codes [7];
  logic [6:0]                           bad   [3];
  int                                   err_count  = 0;
  int                                   n_compared = 0;
  int                                   cyc        = 0;

  always #4 clk_i = ~clk_i;

  tssp_test_select i_dut (
    .clk_i                  (clk_i),
    .rstn_i                 (rstn_i),
    .avs_address_i          (avs_address_i),
    .avs_read_i             (avs_read_i),
    .avs_write_i            (avs_write_i),
    .avs_writedata_i        (avs_writedata_i),
    .avs_byteenable_i       (avs_byteenable_i),
    .avs_readdata_o         (avs_readdata_o),
    .avs_waitrequest_o      (avs_waitrequest_o),
    .normal_output_choice_i (normal_output_choice_i),
    .normal_src_i           (normal_src_i),
    .dig_probe_src_i        (dig_probe_src_i),
    .signal_output_pin_o    (signal_output_pin_o),
    .analog_probe_code_o    (analog_probe_code_o),
    .analog_probe_valid_o   (analog_probe_valid_o)
  );

  task automatic finish_test;
    $display("compared %0d values, %0d mismatches", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Every bus task is entered just after a rising edge and leaves just after one.
  // Waitrequest and read data are read before that edge's updates land.
  task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                          input logic [3:0] be);
    avs_address_i    <= {idx, 2'b00};
    avs_writedata_i  <= {24'h000000, d};
    avs_byteenable_i <= be;
    avs_write_i      <= wr;
    avs_read_i       <= ~wr;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clk_i);
  endtask : bus_xfer

  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask : settle

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    codes = '{tssp_pkg::DIG_S_DATA, tssp_pkg::DIG_S_VALID, tssp_pkg::DIG_S_COLL,
              tssp_pkg::DIG_S_CLOCK, tssp_pkg::DIG_RD_SYNC, tssp_pkg::DIG_WR_SYNC,
              tssp_pkg::DIG_INT_CLOCK};
    bad = '{7'h00, 7'h75, 7'h7F};
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    chk(32'(avs_waitrequest_o), 32'h1);
    // Reset state: analog code 0 valid, no override, pin follows normal_src_i[1].
    bus_xfer(1'b0, tssp_pkg::REG_STATUS_IDX, 8'h00, 4'hF);
    chk(rd, 32'h0000_0090);
    // Presets stay at zero; the reserved byte takes any value and steers nothing.
    bus_xfer(1'b1, tssp_pkg::REG_RESERVED_IDX, 8'hFF, 4'hF);
    bus_xfer(1'b1, tssp_pkg::REG_PRESET_A_IDX, 8'h00, 4'hF);
    bus_xfer(1'b1, tssp_pkg::REG_PRESET_B_IDX, 8'h00, 4'hF);
    for (int a = 8'h39; a <= 8'h3E; a++) begin
      bus_xfer(1'b0, 8'(a), 8'h00, 4'hF);
      chk(rd, 32'h0000_0000);
    end
    bus_xfer(1'b0, tssp_pkg::REG_STATUS_IDX, 8'h00, 4'hF);
    chk(rd, 32'h0000_0090);
    $display("test registers done");
    // Every analog code, upper nibble kept at zero by software.
    for (int c = 0; c < 16; c++) begin
      bus_xfer(1'b1, tssp_pkg::REG_ANALOG_IDX, {4'h0, 4'(c)}, 4'hF);
      settle();
      chk(32'(analog_probe_code_o), 32'(c));
      chk(32'(analog_probe_valid_o), 32'(c <= int'(tssp_pkg::ANA_CODE_MAX)));
    end
    $display("test analog done");
    // Override written without lane 0 must be ignored.
    bus_xfer(1'b1, tssp_pkg::REG_DIGITAL_IDX, 8'hF4, 4'hE);
    bus_xfer(1'b0, tssp_pkg::REG_STATUS_IDX, 8'h00, 4'hF);
    chk(rd, 32'h0000_008F);
    // Override clear with a defined code stored: pin follows the normal choice.
    bus_xfer(1'b1, tssp_pkg::REG_DIGITAL_IDX, 8'h74, 4'hF);
    dig_probe_src_i <= 7'h7F;
    normal_src_i    <= 8'hA5;
    for (int ch = 0; ch < 8; ch++) begin
      normal_output_choice_i <= 3'(ch);
      settle();
      chk(32'(signal_output_pin_o), 32'((8'hA5 >> ch) & 1));
    end
    $display("test normal path done");
    // Each defined code routes its source, both levels, normal path opposite.
    for (int i = 0; i < 7; i++) begin
      bus_xfer(1'b1, tssp_pkg::REG_DIGITAL_IDX, {1'b1, codes[i]}, 4'hF);
      for (int v = 0; v < 2; v++) begin
        dig_probe_src_i <= v ? (7'h01 << i) : ~(7'h01 << i);
        normal_src_i    <= v ? 8'h00 : 8'hFF;
        settle();
        chk(32'(signal_output_pin_o), 32'(v));
      end
    end
    bus_xfer(1'b0, tssp_pkg::REG_STATUS_IDX, 8'h00, 4'hF);
    chk(rd, 32'h0000_16EF);
    $display("test digital codes done");
    // Undefined codes with override give a low pin whatever the sources do.
    dig_probe_src_i <= 7'h7F;
    normal_src_i    <= 8'hFF;
    for (int b = 0; b < 3; b++) begin
      bus_xfer(1'b1, tssp_pkg::REG_DIGITAL_IDX, {1'b1, bad[b]}, 4'hF);
      settle();
      chk(32'(signal_output_pin_o), 32'h0);
    end
    $display("test undefined codes done");
    finish_test();
  end
endmodule : tssp_test_select_tb
